// file: iso_alu.v
// Purpose: result and flag logic for increment, or and move
// Assumes: purely combinational, fed during the process quarter
// Notes:   skip condition is derived here so the sequencer only looks at one bit
`include "iso_exec_defs.vh"

module iso_alu (
	// operation
	input  wire [2:0] i_kind,
	input  wire [7:0] i_acc,
	input  wire [7:0] i_operand,
	input  wire [7:0] i_literal,
	// results
	output reg  [7:0] o_result,
	output wire       o_neg,
	output wire       o_zero,
	output reg        o_skip
);

	always @* begin
		o_result = i_operand;
		o_skip   = 1'b0;
		case (i_kind)
			`ISO_K_INCR_SZ: begin
				o_result = i_operand + `ISO_ONE; // 8-bit wrap
				o_skip   = (o_result == `ISO_RST_BYTE);
			end
			`ISO_K_INCR_SNZ: begin
				o_result = i_operand + `ISO_ONE;
				o_skip   = (o_result != `ISO_RST_BYTE);
			end
			`ISO_K_OR_LIT: o_result = i_acc | i_literal;
			`ISO_K_OR_REG: o_result = i_acc | i_operand;
			`ISO_K_MOVE:   o_result = i_operand;
			default:       o_result = i_operand;
		endcase
	end

	assign o_neg  = o_result[7];
	assign o_zero = (o_result == `ISO_RST_BYTE);

endmodule // iso_alu

// file: iso_exec.v
// Purpose: executes increment-skip, or, pointer load and move instructions
// Assumes: one instruction word is offered per instruction cycle during Q1;
//          the data memory answers a read one clock after the read strobe
// Notes:   the block runs its own quarter counter and shows it on o_quarter
//
// Function
// - increment-skip-if-zero adds one to the addressed file register
// - d=0 sends result to working register, d=1 back to file register
// - zero increment result discards fetched next word, runs a no-op cycle
// - increment-skip-if-not-zero skips only when the result is nonzero
// - skipped two-word instruction costs two full no-op cycles
// - increment-and-skip leaves all status flags unchanged
// - a=0 addresses the operand in the fixed access bank
// - a=1 uses bank select register to pick the register bank
// - a=0 with extended set enabled indexes off pointer 2 for f up to 95
// - or-literal ors working register with literal, writes W, updates N and Z
// - or-register ors W with file register into destination chosen by d
// - pointer load is two words, two cycles, 12-bit literal into pointer 0..2
// - first word gives high nibble to high byte, second word gives low byte
// - move copies a register to the destination by d, updates N and Z
// - one-word instruction: decode Q1, read Q2, process Q3, write Q4
`include "iso_exec_defs.vh"

module iso_exec (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst_n,
	// instruction stream
	input  wire [15:0] i_instr,
	input  wire        i_instr_valid,
	// core state inputs
	input  wire [3:0]  i_bank_select_reg,
	input  wire        i_ext_set_en,
	// data memory
	input  wire [7:0]  i_mem_rdata,
	output reg  [11:0] o_mem_addr,
	output reg         o_mem_rd,
	output reg         o_mem_wr,
	output reg  [7:0]  o_mem_wdata,
	// core state outputs
	output reg  [1:0]  o_quarter,
	output reg  [7:0]  o_acc,
	output reg         o_flag_n,
	output reg         o_flag_z,
	output reg         o_discard,
	output reg  [11:0] o_file_select_pointer0,
	output reg  [11:0] o_file_select_pointer1,
	output reg  [11:0] o_file_select_pointer2
);

	// ****************************************
	// sequencer states
	// ****************************************
	localparam ST_RUN   = 2'b00;
	localparam ST_SKIP  = 2'b01;
	localparam ST_SKIP2 = 2'b10;
	localparam ST_PTR2  = 2'b11;

	reg  [1:0]  state_reg;
	reg  [2:0]  kind_reg;
	reg  [15:0] ir_reg;
	reg  [1:0]  ptr_sel_reg;
	reg  [7:0]  res_reg;
	reg         neg_reg;
	reg         zero_reg;
	reg         skip_reg;

	wire [7:0]  alu_result;
	wire        alu_neg;
	wire        alu_zero;
	wire        alu_skip;

	// ****************************************
	// decode of the offered word
	// ****************************************
	reg  [2:0]  dec_kind;
	reg  [11:0] dec_addr;
	wire [7:0]  dec_f       = i_instr[7:0];
	wire        dec_two_wd  = (i_instr[15:12] == `ISO_OPC_2W_A) ||
	                          (i_instr[15:10] == `ISO_OPC_2W_B);
	wire        dec_reads   = (dec_kind == `ISO_K_INCR_SZ) || (dec_kind == `ISO_K_INCR_SNZ) ||
	                          (dec_kind == `ISO_K_OR_REG) || (dec_kind == `ISO_K_MOVE);
	wire        dest_file   = ir_reg[9] &&
	                          ((kind_reg == `ISO_K_INCR_SZ) || (kind_reg == `ISO_K_INCR_SNZ) ||
	                           (kind_reg == `ISO_K_OR_REG) || (kind_reg == `ISO_K_MOVE));

	always @* begin
		dec_kind = `ISO_K_NOP;
		if (i_instr[15:10] == `ISO_OPC_INCR_SZ)
			dec_kind = `ISO_K_INCR_SZ;
		else if (i_instr[15:10] == `ISO_OPC_INCR_SNZ)
			dec_kind = `ISO_K_INCR_SNZ;
		else if (i_instr[15:8] == `ISO_OPC_OR_LIT)
			dec_kind = `ISO_K_OR_LIT;
		else if (i_instr[15:10] == `ISO_OPC_OR_REG)
			dec_kind = `ISO_K_OR_REG;
		else if (i_instr[15:10] == `ISO_OPC_MOVE)
			dec_kind = `ISO_K_MOVE;
		else if ((i_instr[15:8] == `ISO_OPC_PTR_LD) && (i_instr[7:6] == `ISO_OPC_PTR_SUB))
			dec_kind = `ISO_K_PTR_HI;
	end

	always @* begin
		if (i_instr[8])
			dec_addr = {i_bank_select_reg, dec_f};
		else if (i_ext_set_en && (dec_f <= `ISO_IDX_LIMIT))
			dec_addr = o_file_select_pointer2 + {`ISO_ACC_LO_PAGE, dec_f};
		else if (dec_f < `ISO_ACC_SPLIT)
			dec_addr = {`ISO_ACC_LO_PAGE, dec_f};
		else
			dec_addr = {`ISO_ACC_HI_PAGE, dec_f};
	end

	iso_alu u_alu (
		.i_kind    (kind_reg),
		.i_acc     (o_acc),
		.i_operand (i_mem_rdata),
		.i_literal (ir_reg[7:0]),
		.o_result  (alu_result),
		.o_neg     (alu_neg),
		.o_zero    (alu_zero),
		.o_skip    (alu_skip)
	);

	// ****************************************
	// quarter sequencer and execution
	// ****************************************
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_quarter              <= `ISO_Q1;
			state_reg              <= ST_RUN;
			kind_reg               <= `ISO_K_NOP;
			ir_reg                 <= `ISO_RST_WORD;
			ptr_sel_reg            <= 2'h0;
			res_reg                <= `ISO_RST_BYTE;
			neg_reg                <= 1'b0;
			zero_reg               <= 1'b0;
			skip_reg               <= 1'b0;
			o_mem_addr             <= `ISO_RST_PTR;
			o_mem_rd               <= 1'b0;
			o_mem_wr               <= 1'b0;
			o_mem_wdata            <= `ISO_RST_BYTE;
			o_acc                  <= `ISO_RST_BYTE;
			o_flag_n               <= 1'b0;
			o_flag_z               <= 1'b0;
			o_discard              <= 1'b0;
			o_file_select_pointer0 <= `ISO_RST_PTR;
			o_file_select_pointer1 <= `ISO_RST_PTR;
			o_file_select_pointer2 <= `ISO_RST_PTR;
		end else begin
			o_quarter <= o_quarter + 2'h1;
			case (o_quarter)
				`ISO_Q1: begin
					// decode; the read strobe shows during Q2
					ir_reg    <= i_instr;
					o_discard <= 1'b0;
					o_mem_rd  <= 1'b0;
					kind_reg  <= `ISO_K_NOP;
					case (state_reg)
						ST_SKIP: begin
							// fetched word is thrown away
							o_discard <= 1'b1;
							state_reg <= (i_instr_valid && dec_two_wd) ? ST_SKIP2 : ST_RUN;
						end
						ST_SKIP2: begin
							o_discard <= 1'b1;
							state_reg <= ST_RUN;
						end
						ST_PTR2: begin
							kind_reg  <= `ISO_K_PTR_LO;
							state_reg <= ST_RUN;
						end
						ST_RUN: begin
							if (i_instr_valid) begin
								kind_reg   <= dec_kind;
								o_mem_addr <= dec_addr;
								o_mem_rd   <= dec_reads;
								if (dec_kind == `ISO_K_PTR_HI) begin
									ptr_sel_reg <= i_instr[5:4];
									state_reg   <= ST_PTR2;
								end
							end
						end
						default: state_reg <= ST_RUN;
					endcase
				end
				`ISO_Q2: begin
					o_mem_rd <= 1'b0;
				end
				`ISO_Q3: begin
					// process; file writes show during Q4
					res_reg     <= alu_result;
					neg_reg     <= alu_neg;
					zero_reg    <= alu_zero;
					skip_reg    <= alu_skip;
					o_mem_wr    <= dest_file;
					o_mem_wdata <= alu_result;
				end
				`ISO_Q4: begin
					o_mem_wr <= 1'b0;
					case (kind_reg)
						`ISO_K_INCR_SZ, `ISO_K_INCR_SNZ: begin
							// flags untouched
							if (!ir_reg[9])
								o_acc <= res_reg;
							if (skip_reg)
								state_reg <= ST_SKIP;
						end
						`ISO_K_OR_LIT, `ISO_K_OR_REG, `ISO_K_MOVE: begin
							if (!ir_reg[9] || (kind_reg == `ISO_K_OR_LIT))
								o_acc <= res_reg;
							o_flag_n <= neg_reg;
							o_flag_z <= zero_reg;
						end
						`ISO_K_PTR_HI: begin
							// pointer 3 does not exist; the word then writes nothing
							case (ptr_sel_reg)
								2'h0: o_file_select_pointer0[11:8] <= ir_reg[3:0];
								2'h1: o_file_select_pointer1[11:8] <= ir_reg[3:0];
								2'h2: o_file_select_pointer2[11:8] <= ir_reg[3:0];
								default: ;
							endcase
						end
						`ISO_K_PTR_LO: begin
							case (ptr_sel_reg)
								2'h0: o_file_select_pointer0[7:0] <= ir_reg[7:0];
								2'h1: o_file_select_pointer1[7:0] <= ir_reg[7:0];
								2'h2: o_file_select_pointer2[7:0] <= ir_reg[7:0];
								default: ;
							endcase
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

endmodule // iso_exec

// file: iso_exec_checker.sv
// Purpose: port assertions for the execution block
// Assumes: one clock per quarter, reset async low
// Notes:   address checks watch move words only
`include "iso_exec_defs.vh"

module iso_chk (
	input wire        i_clk_sys, i_rst_n, i_instr_valid, i_ext_set_en,
	input wire [15:0] i_instr,
	input wire [3:0]  i_bank_select_reg,
	input wire [11:0] o_mem_addr, o_file_select_pointer0, o_file_select_pointer2,
	input wire        o_mem_rd, o_mem_wr, o_discard, o_flag_n, o_flag_z,
	input wire [1:0]  o_quarter,
	input wire [7:0]  o_acc
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	wire       tk  = i_instr_valid && o_quarter == `ISO_Q1;
	wire [7:0] f   = i_instr[7:0];
	wire [3:0] pg  = f < `ISO_ACC_SPLIT ? `ISO_ACC_LO_PAGE : `ISO_ACC_HI_PAGE;
	wire       mv  = tk && i_instr[15:10] == `ISO_OPC_MOVE;
	wire       ix  = i_ext_set_en && f <= `ISO_IDX_LIMIT;
	wire       orl = tk && i_instr[15:8] == `ISO_OPC_OR_LIT;
	wire       pl0 = tk && i_instr[15:4] == {`ISO_OPC_PTR_LD, 4'h0};
	wire       inc = tk && (i_instr[15:10] == `ISO_OPC_INCR_SZ ||
	                        i_instr[15:10] == `ISO_OPC_INCR_SNZ);
	// ********
	// checks
	// ********
	chk_rd_quarter: assert property (o_mem_rd |-> o_quarter == `ISO_Q2)
		else $error("read strobe out of slot");
	chk_wr_after_rd: assert property (o_mem_wr |-> o_quarter == `ISO_Q4 && $past(o_mem_rd, 2))
		else $error("write strobe out of slot");
	chk_incr_flags: assert property (inc |=> $stable({o_flag_n, o_flag_z})[*4])
		else $error("flags moved on increment");
	chk_orlit_acc: assert property (
		orl ##1 !o_discard |-> ##4 o_acc == ($past(o_acc, 4) | $past(f, 5)))
		else $error("or literal result wrong");
	chk_orlit_flags: assert property (
		orl ##1 !o_discard |-> ##4 o_flag_z == (o_acc == 8'h00) && o_flag_n == o_acc[7])
		else $error("or literal flags wrong");
	chk_ptr_high: assert property (
		pl0 ##1 !o_discard |-> ##4 o_file_select_pointer0[11:8] == $past(f[3:0], 5))
		else $error("pointer high nibble wrong");
	chk_bank_addr: assert property (
		mv && i_instr[8] ##1 !o_discard |->
		o_mem_addr == {$past(i_bank_select_reg), $past(f)})
		else $error("banked address wrong");
	chk_access_addr: assert property (
		mv && !i_instr[8] && !ix ##1 !o_discard |-> o_mem_addr == {$past(pg), $past(f)})
		else $error("access bank address wrong");
	chk_index_addr: assert property (
		mv && !i_instr[8] && ix ##1 !o_discard |->
		o_mem_addr == $past(o_file_select_pointer2) + {4'h0, $past(f)})
		else $error("indexed address wrong");
	chk_skip_len: assert property ($rose(o_discard) |-> o_discard[*4])
		else $error("discard shorter than a cycle");
	cover property ($rose(o_discard) ##4 o_discard);
	cover property (o_mem_wr);
	cover property (pl0);
endmodule // iso_chk

bind iso_exec iso_chk u_chk (.*);

// file: iso_exec_defs.vh
// Purpose: shared constants for the increment-skip / or / move execution block
// Assumes: one clock cycle per quarter, four quarters per instruction cycle
// Notes:   opcode fields are matched on the upper bits of the instruction word, except the pointer-load sub-field on bits 7:6
`ifndef ISO_EXEC_DEFS_VH
`define ISO_EXEC_DEFS_VH

// ****************************************
// quarter timing
// ****************************************
`define ISO_Q1           2'h0
`define ISO_Q2           2'h1
`define ISO_Q3           2'h2
`define ISO_Q4           2'h3

// ****************************************
// opcode fields
// ****************************************
`define ISO_OPC_INCR_SZ  6'h0F
`define ISO_OPC_INCR_SNZ 6'h12
`define ISO_OPC_OR_REG   6'h04
`define ISO_OPC_MOVE     6'h14
`define ISO_OPC_OR_LIT   8'h09
`define ISO_OPC_PTR_LD   8'hEE
`define ISO_OPC_PTR_SUB  2'h0
`define ISO_OPC_2W_A     4'hC
`define ISO_OPC_2W_B     6'h3B

// ****************************************
// execution kinds
// ****************************************
`define ISO_K_NOP        3'h0
`define ISO_K_INCR_SZ    3'h1
`define ISO_K_INCR_SNZ   3'h2
`define ISO_K_OR_LIT     3'h3
`define ISO_K_OR_REG     3'h4
`define ISO_K_MOVE       3'h5
`define ISO_K_PTR_HI     3'h6
`define ISO_K_PTR_LO     3'h7

// ****************************************
// addressing
// ****************************************
`define ISO_IDX_LIMIT    8'h5F
`define ISO_ACC_SPLIT    8'h60
`define ISO_ACC_LO_PAGE  4'h0
`define ISO_ACC_HI_PAGE  4'hF
`define ISO_ONE          8'h01

// ****************************************
// reset values
// ****************************************
`define ISO_RST_BYTE     8'h00
`define ISO_RST_PTR      12'h000
`define ISO_RST_WORD     16'h0000

`endif

// file: iso_mem_model.sv
// Purpose: data memory beside the execution block
// Assumes: synchronous read, data shown the clock after the strobe
// Notes:   the bench preloads mem through the hierarchy
module iso_mem_model (
	input  wire        i_clk,
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire [11:0] i_addr,
	input  wire [7:0]  i_wdata,
	output logic [7:0] o_rdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	always @(posedge i_clk) begin
		if (i_wr) mem[i_addr] <= i_wdata;
		// stale data must never look valid, so idle cycles invert the bus
		o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
	end
endmodule // iso_mem_model

// file: tb_incr_skip_or_move_exec.sv
// Purpose: self-checking bench for the execution block
// Assumes: one word per four clocks, driven at falling edges
// Notes:   expected memory writes wait in a queue for the monitor
module tb_incr_skip_or_move_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk_sys = 0, i_rst_n = 0, i_instr_valid = 0, i_ext_set_en = 0;
	logic        fn = 0, fz = 0, pend = 0;
	logic [15:0] i_instr = 16'h0000, w;
	logic [3:0]  i_bank_select_reg = 4'h0;
	logic [7:0]  acc = 8'h00, sh [4096];
	logic [11:0] ptr [3] = '{default: 12'h000};
	logic [19:0] q [$];
	logic [1:0]  ps;
	wire  [11:0] o_mem_addr, o_file_select_pointer0;
	wire  [11:0] o_file_select_pointer1, o_file_select_pointer2;
	wire  [7:0]  i_mem_rdata, o_mem_wdata, o_acc;
	wire  [1:0]  o_quarter;
	wire         o_mem_rd, o_mem_wr, o_flag_n, o_flag_z, o_discard;
	int          errors = 0, n_compared = 0, seed = 14785, skip_n = 0, k;
	logic [7:0]  ops [8] = '{8'h3C, 8'h48, 8'h10, 8'h50, 8'h08, 8'h09, 8'hEE, 8'hC0};
	logic [15:0] dir [20] = '{16'h3E10, 16'hC123, 16'hF456, 16'h3C10, 16'h4811, 16'h0955,
		16'h5011, 16'h0980, 16'hEE2A, 16'h00BC, 16'hEE05, 16'h0077, 16'h1205, 16'h5290,
		16'h5112, 16'hEE30, 16'h0012, 16'h1012, 16'h3F44, 16'h4A10};

	always #4 i_clk_sys = ~i_clk_sys;
	iso_exec DUT (.*);
	iso_mem_model u_mem (.i_clk(i_clk_sys), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	// ********
	// checking
	// ********
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge i_clk_sys) if (o_mem_wr) begin
		if (q.size() == 0) chk(20'h0_0000, 20'hF_FFFF);
		else chk({o_mem_addr, o_mem_wdata}, q.pop_front());
	end

	task automatic dst(input logic d, input logic [11:0] ad, input logic [7:0] r, input logic fl);
		if (d) begin
			sh[ad] = r;
			q.push_back({ad, r});
		end else acc = r;
		if (fl) {fn, fz} = {r[7], r == 8'h00};
	endtask

	// one instruction cycle: offer a word, predict, then compare at the next Q1
	task automatic run(input logic [15:0] wd, input logic v);
		logic [11:0] ad;
		logic [7:0]  f, r;
		logic        sk;
		for (int i = 0; i < 8 && o_quarter !== 2'h0; i++) @(negedge i_clk_sys);
		if (o_quarter !== 2'h0) begin
			chk(20'h0_0000, 20'h0_0001);
			end_sim();
		end
		i_instr = wd;
		i_instr_valid = v;
		i_bank_select_reg = 4'($random(seed));
		f = wd[7:0];
		sk = skip_n > 0;
		ad = wd[8] ? {i_bank_select_reg, f} : (i_ext_set_en && f <= 8'h5F) ? ptr[2] + f
			: {f < 8'h60 ? 4'h0 : 4'hF, f};
		// an empty slot during a skip is a single word, never the head of a two-word one
		if (sk) skip_n = v && skip_n == 2 &&
			(wd[15:12] == 4'hC || wd[15:10] == 6'h3B);
		else if (pend) begin
			if (ps != 2'h3) ptr[ps][7:0] = f;
			pend = 0;
		end else if (v) case (wd[15:10])
			6'h0F, 6'h12: begin
				r = sh[ad] + 8'h01;
				dst(wd[9], ad, r, 1'b0);
				if ((r == 8'h00) == (wd[15:10] == 6'h0F)) skip_n = 2;
			end
			6'h04: dst(wd[9], ad, acc | sh[ad], 1'b1);
			6'h14: dst(wd[9], ad, sh[ad], 1'b1);
			default: if (wd[15:8] == 8'h09) dst(1'b0, ad, acc | f, 1'b1);
			else if (wd[15:6] == 10'h3B8) begin
				ps = wd[5:4];
				pend = 1;
				if (ps != 2'h3) ptr[ps][11:8] = wd[3:0];
			end
		endcase
		repeat (4) @(negedge i_clk_sys);
		chk({o_flag_n, o_flag_z, o_discard, o_acc}, {fn, fz, sk, acc});
		chk(o_file_select_pointer0, ptr[0]);
		chk(o_file_select_pointer1, ptr[1]);
		chk(o_file_select_pointer2, ptr[2]);
	endtask

	initial begin
		for (int i = 0; i < 4096; i++) begin
			sh[i] = i == 16 ? 8'hFF : i == 17 ? 8'h00 : 8'($random(seed));
			u_mem.mem[i] = sh[i];
		end
		repeat (8) @(negedge i_clk_sys);
		i_rst_n = 1;
		for (int i = 0; i < 20; i++) begin
			i_ext_set_en = i > 11;
			run(dir[i], !(i == 9 || i == 19));
		end
		for (int n = 0; n < 80; n++) begin
			k = 3'($random(seed));
			i_ext_set_en = 1'($random(seed));
			w = {ops[k], 8'($random(seed))};
			if (k < 4) w[9:8] = 2'($random(seed));
			if (k == 6) w[7:6] = 2'h0;
			run(w, 3'($random(seed)) != 3'h0);
			if (k == 6) run({8'h00, 8'($random(seed))}, 1'b1);
		end
		chk(20'(q.size()), 20'h0_0000);
		end_sim();
	end
endmodule // tb_incr_skip_or_move_exec
